// ===== prio_pkg.sv
// Purpose: Shared constants for the priority shadow trap block
// Assumes: 32-bit register port, 25 MHz core clock
// Notes:   Offsets are word aligned byte addresses
package prio_pkg;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_FLOOR      = 8'h04;
  localparam logic [7:0]  ADDR_PAGE_LO    = 8'h08;
  localparam logic [7:0]  ADDR_PAGE_HI    = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS     = 8'h10;
  localparam logic [7:0]  ADDR_MASK       = 8'h14;
  localparam logic [7:0]  ADDR_EXIT       = 8'h18;
  localparam logic [7:0]  ADDR_PHYS       = 8'h1C;
  localparam logic [7:0]  ADDR_VECTOR     = 8'h20;
  localparam logic [11:0] SHADOW_OFFSET   = 12'h080;
  localparam int          CTRL_SHADOW_EN  = 0;
  localparam int          CTRL_RD_TRAP    = 1;
  localparam int          CTRL_WR_TRAP    = 2;
  localparam int          ST_EXIT         = 0;
  localparam int          ST_BAD_VECTOR   = 1;
  localparam logic [7:0]  VECTOR_MIN      = 8'h20;
  localparam logic [7:0]  VECTOR_MAX      = 8'hFF;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] FLOOR_RESET     = 32'h0000_0000;
  localparam logic [7:0]  SHADOW_RESET    = 8'h00;
  localparam logic [3:0]  PHYS_RESET      = 4'h0;
  localparam logic [1:0]  MASK_RESET      = 2'h0;
  typedef enum logic [2:0] {
    REASON_NONE     = 3'b000,
    REASON_RD_TRAP  = 3'b001,
    REASON_WR_TRAP  = 3'b010,
    REASON_FLOOR    = 3'b011
  } exit_reason_t;
endpackage : prio_pkg

// ===== sticky_bit.sv
// Purpose: One write-one-to-clear sticky flag
// Assumes: Set and clear come from the core clock domain
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ns
module sticky_bit (
  input  wire logic clock_i,   // Core clock
  input  wire logic sys_rst_i, // Sync reset
  input  wire logic set_i,     // Event
  input  wire logic clr_i,     // Write one to clear
  output logic      flag_o     // Sticky flag
);
  logic next_flag;
  always_comb begin
    next_flag = flag_o;
    if (clr_i) begin
      next_flag = 1'b0;
    end
    if (set_i) begin
      next_flag = 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end
endmodule : sticky_bit

// ===== floor_compare.sv
// Purpose: Compare the priority shadow level against the floor
// Assumes: Both operands are 4-bit priority classes
// Notes:   Pure combinational
`timescale 1ns/1ns
module floor_compare (
  input  wire logic [7:0] shadow_i, // Shadow byte
  input  wire logic [3:0] floor_i,  // Floor value
  output logic            below_o   // Shadow below floor
);
  always_comb begin
    below_o = (shadow_i[7:4] < floor_i);
  end
endmodule : floor_compare

// ===== priority_shadow_trap.sv
// Purpose: Serve guest priority control register accesses from a shadow or trap them
// Assumes: Guest access strobes are one cycle and come from core logic
// Notes:   Shadow byte lives here; page address is only reported
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module priority_shadow_trap
  import prio_pkg::*;
(
  input  wire logic               clock_i,      // Core clock
  input  wire logic               sys_rst_i,    // Sync reset
  input  wire logic [7:0]         addr_i,       // Register address
  input  wire logic [31:0]        wdata_i,      // Register write data
  input  wire logic               wr_i,         // Register write strobe
  input  wire logic               rd_i,         // Register read strobe
  output logic [31:0]             rdata_o,      // Register read data
  input  wire logic               guest_rd_i,   // Guest read of priority control
  input  wire logic               guest_wr_i,   // Guest write of priority control
  input  wire logic [3:0]         guest_wdata_i,// Guest write value
  input  wire logic               vec_valid_i,  // External vector delivered
  input  wire logic [7:0]         vec_i,        // External vector
  output logic                    guest_rvalid_o,// Guest read answered
  output logic [3:0]              guest_rdata_o,// Guest read value
  output logic                    exit_o,       // Exit to hypervisor pulse
  output prio_pkg::exit_reason_t  exit_reason_o,// Exit reason
  output logic [63:0]             shadow_addr_o,// Physical address of shadow byte
  output logic [3:0]              phys_prio_o,  // Physical priority register
  output logic                    irq_o         // Interrupt
);
  import prio_pkg::*;

  logic [31:0]  ctrl, next_ctrl;
  logic [31:0]  floor_reg, next_floor;
  logic [63:0]  page_addr, next_page;
  logic [7:0]   shadow, next_shadow;
  logic [3:0]   phys, next_phys;
  logic [1:0]   mask, next_mask;
  logic [7:0]   last_vec, next_last_vec;
  logic         floor_pend, next_floor_pend;
  logic         exit_q, next_exit;
  exit_reason_t reason_q, next_reason, last_reason, next_last_reason;
  logic         rvalid_q, next_rvalid;
  logic [3:0]   grdata_q, next_grdata;
  logic [31:0]  rdata_q, next_rdata;
  logic [1:0]   status;
  logic         below;
  logic         shadow_en, rd_trap, wr_trap;
  logic         exit_evt, bad_vec_evt;
  logic [1:0]   st_clr;
  logic         next_irq;
  logic [63:0]  next_shadow_addr;

  assign shadow_en = ctrl[CTRL_SHADOW_EN];
  assign rd_trap   = ctrl[CTRL_RD_TRAP];
  assign wr_trap   = ctrl[CTRL_WR_TRAP];

  floor_compare u_cmp (
    .shadow_i (shadow),
    .floor_i  (floor_reg[3:0]),
    .below_o  (below)
  );

  // Guest access path
  always_comb begin
    next_shadow     = shadow;
    next_phys       = phys;
    next_exit       = 1'b0;
    next_reason     = REASON_NONE;
    next_rvalid     = 1'b0;
    next_grdata     = 4'h0;
    next_floor_pend = 1'b0;
    if (floor_pend && below) begin
      // Compare one cycle after the write so it sees the stored shadow
      next_exit   = 1'b1;
      next_reason = REASON_FLOOR;
    end
    if (guest_rd_i) begin
      if (rd_trap) begin
        next_exit   = 1'b1;
        next_reason = REASON_RD_TRAP;
      end else if (shadow_en) begin
        next_rvalid = 1'b1;
        next_grdata = shadow[7:4];
      end else begin
        next_rvalid = 1'b1;
        next_grdata = phys;
      end
    end
    if (guest_wr_i) begin
      if (wr_trap) begin
        next_exit   = 1'b1;
        next_reason = REASON_WR_TRAP;
      end else if (shadow_en) begin
        next_shadow     = {guest_wdata_i, shadow[3:0]};
        next_floor_pend = 1'b1;
      end else begin
        next_phys = guest_wdata_i;
      end
    end
  end

  // Register port
  always_comb begin
    next_ctrl        = ctrl;
    next_floor       = floor_reg;
    next_page        = page_addr;
    next_mask        = mask;
    next_rdata       = 32'h0000_0000;
    next_last_vec    = last_vec;
    next_last_reason = last_reason;
    st_clr           = 2'b00;
    if (exit_q) begin
      next_last_reason = reason_q;
    end
    if (vec_valid_i) begin
      next_last_vec = vec_i;
    end
    if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL:    next_ctrl  = {29'h0000_0000, wdata_i[2:0]};
        ADDR_FLOOR:   next_floor = {28'h000_0000, wdata_i[3:0]};
        ADDR_PAGE_LO: next_page  = {page_addr[63:32], wdata_i[31:12], 12'h000};
        ADDR_PAGE_HI: next_page  = {wdata_i, page_addr[31:0]};
        ADDR_STATUS:  st_clr     = wdata_i[1:0];
        ADDR_MASK:    next_mask  = wdata_i[1:0];
        default:      next_ctrl  = ctrl;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL:    next_rdata = ctrl;
        ADDR_FLOOR:   next_rdata = floor_reg;
        ADDR_PAGE_LO: next_rdata = page_addr[31:0];
        ADDR_PAGE_HI: next_rdata = page_addr[63:32];
        ADDR_STATUS:  next_rdata = {30'h0000_0000, status};
        ADDR_MASK:    next_rdata = {30'h0000_0000, mask};
        ADDR_EXIT:    next_rdata = {21'h00_0000, shadow, last_reason};
        ADDR_PHYS:    next_rdata = {28'h000_0000, phys};
        ADDR_VECTOR:  next_rdata = {24'h00_0000, last_vec};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign exit_evt    = exit_q;
  // Vectors below 20H are reserved for exceptions
  assign bad_vec_evt = vec_valid_i && ((vec_i < VECTOR_MIN) || (vec_i > VECTOR_MAX));

  sticky_bit u_st_exit (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (exit_evt),
    .clr_i     (st_clr[ST_EXIT]),
    .flag_o    (status[ST_EXIT])
  );

  sticky_bit u_st_vec (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (bad_vec_evt),
    .clr_i     (st_clr[ST_BAD_VECTOR]),
    .flag_o    (status[ST_BAD_VECTOR])
  );

  // Interrupt and address outputs
  always_comb begin
    next_irq         = |(status & mask);
    // Built from the next page so the address moves with the page register itself
    next_shadow_addr = {next_page[63:12], SHADOW_OFFSET};
  end

  // Guest access state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      shadow         <= SHADOW_RESET;
      phys           <= PHYS_RESET;
      floor_pend     <= 1'b0;
      exit_q         <= 1'b0;
      reason_q       <= REASON_NONE;
      rvalid_q       <= 1'b0;
      grdata_q       <= 4'h0;
    end else begin
      shadow         <= next_shadow;
      phys           <= next_phys;
      floor_pend     <= next_floor_pend;
      exit_q         <= next_exit;
      reason_q       <= next_reason;
      rvalid_q       <= next_rvalid;
      grdata_q       <= next_grdata;
    end
  end

  // Register port state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl           <= CTRL_RESET;
      floor_reg      <= FLOOR_RESET;
      page_addr      <= 64'h0000_0000_0000_0000;
      mask           <= MASK_RESET;
      last_vec       <= 8'h00;
      last_reason    <= REASON_NONE;
      rdata_q        <= 32'h0000_0000;
    end else begin
      ctrl           <= next_ctrl;
      floor_reg      <= next_floor;
      page_addr      <= next_page;
      mask           <= next_mask;
      last_vec       <= next_last_vec;
      last_reason    <= next_last_reason;
      rdata_q        <= next_rdata;
    end
  end

  // Output flops
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_o          <= 1'b0;
      shadow_addr_o  <= 64'h0000_0000_0000_0000;
    end else begin
      irq_o          <= next_irq;
      shadow_addr_o  <= next_shadow_addr;
    end
  end

  assign rdata_o        = rdata_q;
  assign exit_o         = exit_q;
  assign exit_reason_o  = reason_q;
  assign guest_rvalid_o = rvalid_q;
  assign guest_rdata_o  = grdata_q;
  assign phys_prio_o    = phys;
endmodule : priority_shadow_trap

// ===== prio_trap_props.sv
// Purpose: Port-level checks for priority_shadow_trap
// Assumes: Control and floor are mirrored from register writes
// Notes:   A guest access right after a shadow write is excluded from floor checks
`timescale 1ns/1ns
module prio_trap_props
  import prio_pkg::*;
(
  input wire logic                  clock_i,        // Core clock
  input wire logic                  sys_rst_i,      // Sync reset
  input wire logic [7:0]            addr_i,         // Register address
  input wire logic [31:0]           wdata_i,        // Register write data
  input wire logic                  wr_i,           // Write strobe
  input wire logic                  guest_rd_i,     // Guest read
  input wire logic                  guest_wr_i,     // Guest write
  input wire logic [3:0]            guest_wdata_i,  // Guest value
  input wire logic                  guest_rvalid_o, // Read answered
  input wire logic                  exit_o,         // Exit pulse
  input wire prio_pkg::exit_reason_t exit_reason_o, // Exit reason
  input wire logic [63:0]           shadow_addr_o,  // Shadow address
  input wire logic [3:0]            phys_prio_o     // Physical priority
);
  logic [2:0] ctrl_seen;
  logic [2:0] next_ctrl_seen;
  logic [3:0] floor_seen;
  logic [3:0] next_floor_seen;
  wire        idle_next = !(guest_rd_i || guest_wr_i);
  always_comb begin
    next_ctrl_seen = ctrl_seen;
    next_floor_seen = floor_seen;
    if (wr_i && addr_i == ADDR_CTRL) next_ctrl_seen = wdata_i[2:0];
    if (wr_i && addr_i == ADDR_FLOOR) next_floor_seen = wdata_i[3:0];
  end
  always_ff @(posedge clock_i) begin
    ctrl_seen <= sys_rst_i ? 3'h0 : next_ctrl_seen;
    floor_seen <= sys_rst_i ? 4'h0 : next_floor_seen;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd_trap; guest_rd_i && ctrl_seen[1] |=> exit_o && exit_reason_o == REASON_RD_TRAP; endproperty
  a_rd_trap: assert property (p_rd_trap) else $error("read trap exit missing");
  property p_wr_trap; guest_wr_i && ctrl_seen[2] |=> exit_o && exit_reason_o == REASON_WR_TRAP; endproperty
  a_wr_trap: assert property (p_wr_trap) else $error("write trap exit missing");
  property p_wr_hold; guest_wr_i && ctrl_seen[2] |=> $stable(phys_prio_o); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("trapped write took effect");
  property p_rd_shadow; guest_rd_i && ctrl_seen[0] && !ctrl_seen[1] |=> guest_rvalid_o && !exit_o; endproperty
  a_rd_shadow: assert property (p_rd_shadow) else $error("shadow read not answered");
  property p_floor;
    (guest_wr_i && ctrl_seen[0] && !ctrl_seen[2] && guest_wdata_i < floor_seen) ##1 idle_next
      |=> exit_o && exit_reason_o == REASON_FLOOR;
  endproperty
  a_floor: assert property (p_floor) else $error("floor exit missing");
  property p_no_floor;
    (guest_wr_i && ctrl_seen[0] && !ctrl_seen[2] && guest_wdata_i >= floor_seen) ##1 idle_next |=> !exit_o;
  endproperty
  a_no_floor: assert property (p_no_floor) else $error("spurious floor exit");
  property p_phys; guest_wr_i && ctrl_seen == 3'h0 |=> phys_prio_o == $past(guest_wdata_i); endproperty
  a_phys: assert property (p_phys) else $error("physical priority not written");
  property p_addr;
    wr_i && addr_i == ADDR_PAGE_LO |-> ##2 shadow_addr_o[31:0] == {$past(wdata_i[31:12], 2), SHADOW_OFFSET};
  endproperty
  a_addr: assert property (p_addr) else $error("shadow address wrong");
  c_rd_trap: cover property (guest_rd_i && ctrl_seen[1]);
  c_floor: cover property (exit_o && exit_reason_o == REASON_FLOOR);
  c_shadow: cover property (guest_rvalid_o && ctrl_seen[0]);
endmodule : prio_trap_props
bind priority_shadow_trap prio_trap_props chk_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .guest_rd_i(guest_rd_i), .guest_wr_i(guest_wr_i), .guest_wdata_i(guest_wdata_i),
  .guest_rvalid_o(guest_rvalid_o), .exit_o(exit_o), .exit_reason_o(exit_reason_o), .shadow_addr_o(shadow_addr_o),
  .phys_prio_o(phys_prio_o));

// ===== priority_shadow_trap_tb_top.sv
// Purpose: Directed bench for priority_shadow_trap
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes:   Guest accesses are spaced so floor exits are never overridden
`timescale 1ns/1ns
module priority_shadow_trap_tb_top;
  import prio_pkg::*;
  logic clock_i = '0, sys_rst_i = 1'b1, wr_i = '0, rd_i = '0, guest_rd_i = '0, guest_wr_i = '0, vec_valid_i = '0;
  logic [7:0]   addr_i = '0, vec_i = '0;
  logic [31:0]  wdata_i = '0, rdata_o;
  logic [3:0]   guest_wdata_i = '0, guest_rdata_o, phys_prio_o;
  logic         guest_rvalid_o, exit_o, irq_o;
  exit_reason_t exit_reason_o;
  logic [63:0]  shadow_addr_o;
  int           miscompares = 0, n_checks = 0;
  priority_shadow_trap dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .guest_rd_i(guest_rd_i), .guest_wr_i(guest_wr_i),
    .guest_wdata_i(guest_wdata_i), .vec_valid_i(vec_valid_i), .vec_i(vec_i), .guest_rvalid_o(guest_rvalid_o),
    .guest_rdata_o(guest_rdata_o), .exit_o(exit_o), .exit_reason_o(exit_reason_o), .shadow_addr_o(shadow_addr_o),
    .phys_prio_o(phys_prio_o), .irq_o(irq_o));
  initial forever #20 clock_i = ~clock_i;
  task print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd
  // Looks at both the answer cycle and the floor-exit cycle after it
  task gop(input logic r, input logic w, input logic [3:0] v, input logic [8:0] e1, input logic [3:0] e2);
    @(posedge clock_i);
    guest_rd_i <= r;
    guest_wr_i <= w;
    guest_wdata_i <= v;
    @(posedge clock_i);
    guest_rd_i <= 1'b0;
    guest_wr_i <= 1'b0;
    #1 chk({guest_rvalid_o, guest_rdata_o, exit_o, exit_reason_o}, e1);
    @(posedge clock_i);
    #1 chk({exit_o, exit_reason_o}, e2);
  endtask : gop
  task vec(input logic [7:0] v);
    @(posedge clock_i);
    vec_valid_i <= 1'b1;
    vec_i <= v;
    @(posedge clock_i);
    vec_valid_i <= 1'b0;
  endtask : vec
  task irqc(input logic e);
    @(posedge clock_i);
    #1 chk(irq_o, e);
  endtask : irqc
  initial begin
    repeat (3000) @(posedge clock_i);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_PHYS, 32'h0);
    rd(8'h40, 32'h0);
    gop(1'b0, 1'b1, 4'h9, 9'h000, 4'h0);
    chk(phys_prio_o, 64'h9);
    gop(1'b1, 1'b0, 4'h0, 9'h190, 4'h0);
    wr(ADDR_PAGE_LO, 32'h1234_5FFF);
    wr(ADDR_PAGE_HI, 32'h0000_00AB);
    @(posedge clock_i);
    #1 chk(shadow_addr_o, 64'h0000_00AB_1234_5080);
    $display("test setup done");
    wr(ADDR_FLOOR, 32'hFFFF_FFF4);
    rd(ADDR_FLOOR, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    gop(1'b0, 1'b1, 4'h4, 9'h000, 4'h0);
    rd(ADDR_EXIT, 32'h200);
    gop(1'b1, 1'b0, 4'h0, 9'h140, 4'h0);
    gop(1'b0, 1'b1, 4'h3, 9'h000, {1'b1, REASON_FLOOR});
    rd(ADDR_EXIT, 32'h183);
    chk(phys_prio_o, 64'h9);
    wr(ADDR_CTRL, 32'h2);
    gop(1'b1, 1'b0, 4'h0, {5'h00, 1'b1, REASON_RD_TRAP}, 4'h0);
    wr(ADDR_CTRL, 32'h4);
    gop(1'b0, 1'b1, 4'h7, {5'h00, 1'b1, REASON_WR_TRAP}, 4'h0);
    rd(ADDR_EXIT, 32'h182);
    chk(phys_prio_o, 64'h9);
    wr(ADDR_CTRL, 32'h7);
    gop(1'b1, 1'b0, 4'h0, {5'h00, 1'b1, REASON_RD_TRAP}, 4'h0);
    gop(1'b0, 1'b1, 4'h1, {5'h00, 1'b1, REASON_WR_TRAP}, 4'h0);
    rd(ADDR_EXIT, 32'h182);
    $display("test guest done");
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_MASK, 32'h1);
    irqc(1'b1);
    wr(ADDR_STATUS, 32'h1);
    irqc(1'b0);
    vec(8'h1F);
    vec(8'h20);
    rd(ADDR_STATUS, 32'h2);
    irqc(1'b0);
    rd(ADDR_VECTOR, 32'h20);
    wr(ADDR_MASK, 32'h3);
    irqc(1'b1);
    $display("test irq done");
    print_verdict();
  end
endmodule : priority_shadow_trap_tb_top
